// ---- pfc_pkg.sv ----
// Package for the parallel flash host controller: register map, codes, timing
package pfc_pkg;
  localparam int CLK_HZ = 40_000_000;
  localparam int CLK_NS = 25;
  // Bus timing of one flash cycle, in ns, rounded up to clocks
  localparam int T_STROBE_NS = 50;
  localparam int T_SETUP_NS = 25;
  localparam int T_READ_NS = 75;
  localparam int STROBE_CYC = (T_STROBE_NS + CLK_NS - 1) / CLK_NS;
  localparam int SETUP_CYC = (T_SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int READ_CYC = (T_READ_NS + CLK_NS - 1) / CLK_NS;
  localparam int TIMER_W = 4;
  // Longest byte program, and the poll budget for programs and erases (polls)
  localparam int PROG_MAX_US = 20;
  localparam int PROG_MAX_CYC = PROG_MAX_US * (CLK_HZ / 1_000_000);
  localparam int POLL_LIMIT = 32'h0100_0000;
  // Register offsets (byte addresses)
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_DATA = 8'h08;
  localparam logic [7:0] REG_STAT = 8'h0c;
  localparam logic [7:0] REG_RDATA = 8'h10;
  // Control field: start bit and operation code
  localparam int CTRL_START = 8;
  localparam int CTRL_OP_LSB = 0;
  localparam int CTRL_OP_W = 3;
  // Status field positions
  localparam int STAT_BUSY = 0;
  localparam int STAT_DONE = 1;
  localparam int STAT_FAIL = 2;
  localparam int STAT_ID = 3;
  // Flash command addresses and codes
  localparam logic [18:0] A_UNLOCK1 = 19'h05555;
  localparam logic [18:0] A_UNLOCK2 = 19'h02aaa;
  localparam logic [7:0] D_UNLOCK1 = 8'haa;
  localparam logic [7:0] D_UNLOCK2 = 8'h55;
  localparam logic [7:0] C_PROGRAM = 8'ha0;
  localparam logic [7:0] C_ERASE = 8'h80;
  localparam logic [7:0] C_SECTOR = 8'h30;
  localparam logic [7:0] C_CHIP = 8'h10;
  localparam logic [7:0] C_ID_ENTRY = 8'h90;
  localparam logic [7:0] C_ID_EXIT = 8'hf0;
  localparam int SECTOR_LSB = 12;
  localparam int POLL_BIT = 7;
  localparam int FLIP_BIT = 6;
  localparam int REREADS = 2;
  typedef enum logic [2:0] {
    OP_READ, OP_PROGRAM, OP_SECTOR, OP_CHIP, OP_ID_ENTRY, OP_ID_EXIT
  } pfc_op_e;
  // Pin bundle toward the flash
  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic [18:0] addr;
    logic [7:0] dq_out;
    logic dq_oe_n;
  } pfc_pins_s;
  // One flash bus cycle request
  typedef struct packed {
    logic write;
    logic [18:0] addr;
    logic [7:0] data;
  } pfc_cyc_s;
endpackage : pfc_pkg

// ---- pfc_cycle.sv ----
// One flash bus cycle: write strobe or read sample on the parallel pins
`timescale 1ns/1ps
module pfc_cycle (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic req_valid,
  output logic req_ready,
  input pfc_pkg::pfc_cyc_s req,
  output logic done,
  output logic [7:0] rdata,
  output pfc_pkg::pfc_pins_s pins,
  input wire logic [7:0] dq_in
);
  typedef enum {CY_IDLE, CY_SETUP, CY_STROBE, CY_HOLD} pfc_cy_e;
  pfc_cy_e state;
  logic [pfc_pkg::TIMER_W-1:0] timer;
  logic [7:0] dq_s1;
  logic [7:0] dq_s2;
  logic wr;

  assign req_ready = (state == CY_IDLE);

  // Pin data is asynchronous to our clock; two flops before use
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      dq_s1 <= 8'h00;
      dq_s2 <= 8'h00;
    end else begin
      dq_s1 <= dq_in;
      dq_s2 <= dq_s1;
    end
  end

  // Sequencer: address settles, then strobe, then release with data still held
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state <= CY_IDLE;
      timer <= '0;
      wr <= 1'b0;
      done <= 1'b0;
      rdata <= 8'h00;
      pins <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: 19'h00000,
                dq_out: 8'h00, dq_oe_n: 1'b1};
    end else begin
      done <= 1'b0;
      case (state)
        CY_IDLE: begin
          if (req_valid) begin
            wr <= req.write;
            pins.addr <= req.addr;
            pins.dq_out <= req.data;
            pins.ce_n <= 1'b0;
            // OE stays high during writes so the flash does not inhibit them
            pins.dq_oe_n <= !req.write;
            timer <= pfc_pkg::TIMER_W'(pfc_pkg::SETUP_CYC);
            state <= CY_SETUP;
          end
        end
        CY_SETUP: begin
          if (timer > 1) begin
            timer <= timer - 1'b1;
          end else begin
            // Address latched at the falling WE edge, CE already low
            pins.we_n <= !wr;
            pins.oe_n <= wr;
            timer <= pfc_pkg::TIMER_W'(wr ? pfc_pkg::STROBE_CYC : pfc_pkg::READ_CYC);
            state <= CY_STROBE;
          end
        end
        CY_STROBE: begin
          // Strobe held 50 ns, far beyond the glitch filter
          if (timer > 1) begin
            timer <= timer - 1'b1;
          end else begin
            pins.we_n <= 1'b1;
            pins.oe_n <= 1'b1;
            if (!wr) begin
              rdata <= dq_s2;
            end
            state <= CY_HOLD;
          end
        end
        CY_HOLD: begin
          // Data held one cycle past the rising WE so the latch sees it
          pins.ce_n <= 1'b1;
          pins.dq_oe_n <= 1'b1;
          done <= 1'b1;
          state <= CY_IDLE;
        end
        default: state <= CY_IDLE;
      endcase
    end
  end

  a_write_no_oe: assert property (@(posedge clock) disable iff (!arst_n)
    !pins.we_n |-> pins.oe_n && !pins.ce_n)
    else $error("write strobe with output enable low");
  a_drive_not_read: assert property (@(posedge clock) disable iff (!arst_n)
    !pins.oe_n |-> pins.dq_oe_n)
    else $error("host drives bus while flash outputs");
  a_strobe_width: assert property (@(posedge clock) disable iff (!arst_n)
    $fell(pins.we_n) |-> !pins.we_n [*2])
    else $error("write strobe too short");
  a_data_hold: assert property (@(posedge clock) disable iff (!arst_n)
    $rose(pins.we_n) |-> !pins.dq_oe_n && $stable(pins.dq_out))
    else $error("data released at strobe rise");
endmodule : pfc_cycle

// ---- pfc_host.sv ----
// Host controller for a byte-wide parallel flash, commanded over APB
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
module pfc_host #(
  parameter int POLL_MAX = pfc_pkg::POLL_LIMIT
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output pfc_pkg::pfc_pins_s pins,
  input wire logic [7:0] dq_in
);
  // Refuse a poll budget that could never let an operation finish
  if (POLL_MAX < 1) begin : g_bad_poll
    $error("poll budget must be positive");
  end

  typedef enum {ST_IDLE, ST_SEQ, ST_POLL, ST_CHECK, ST_FIN} pfc_st_e;
  pfc_st_e state;
  pfc_pkg::pfc_op_e op;
  logic [18:0] tgt_addr;
  logic [7:0] tgt_data;
  logic busy, done_flag, fail_flag, id_mode;
  logic [7:0] read_data;
  logic [2:0] step;
  logic [1:0] recheck;
  logic [7:0] prev_rd;
  logic have_prev;
  logic [31:0] poll_cnt;
  logic cyc_valid, cyc_ready, cyc_done;
  pfc_pkg::pfc_cyc_s cyc_req;
  logic [7:0] cyc_rdata;
  logic issued;

  // Sequence length for each operation
  function automatic logic [2:0] seq_len(input pfc_pkg::pfc_op_e o);
    case (o)
      pfc_pkg::OP_PROGRAM: seq_len = 3'd4;
      pfc_pkg::OP_SECTOR, pfc_pkg::OP_CHIP: seq_len = 3'd6;
      pfc_pkg::OP_ID_ENTRY, pfc_pkg::OP_ID_EXIT: seq_len = 3'd3;
      default: seq_len = 3'd1;
    endcase
  endfunction : seq_len

  // The n-th bus cycle of an operation; steps 0,1 and, for erases, 3,4 are unlock pairs
  function automatic pfc_pkg::pfc_cyc_s seq_cyc(input pfc_pkg::pfc_op_e o,
      input logic [2:0] s, input logic [18:0] a, input logic [7:0] d);
    pfc_pkg::pfc_cyc_s c;
    c = '{write: 1'b1, addr: pfc_pkg::A_UNLOCK1, data: pfc_pkg::D_UNLOCK1};
    if (s == 3'd1 || s == 3'd4) begin
      c.addr = pfc_pkg::A_UNLOCK2;
      c.data = pfc_pkg::D_UNLOCK2;
    end else if (s == 3'd2) begin
      case (o)
        pfc_pkg::OP_PROGRAM: c.data = pfc_pkg::C_PROGRAM;
        pfc_pkg::OP_SECTOR, pfc_pkg::OP_CHIP: c.data = pfc_pkg::C_ERASE;
        pfc_pkg::OP_ID_ENTRY: c.data = pfc_pkg::C_ID_ENTRY;
        default: c.data = pfc_pkg::C_ID_EXIT;
      endcase
    end else if (s == 3'd3 && o == pfc_pkg::OP_PROGRAM) begin
      c.addr = a;
      c.data = d;
    end else if (s == 3'd5) begin
      if (o == pfc_pkg::OP_SECTOR) begin
        // Only the sector lines matter; the low twelve bits are cleared
        c.addr = {a[18:pfc_pkg::SECTOR_LSB], 12'h000};
        c.data = pfc_pkg::C_SECTOR;
      end else begin
        c.data = pfc_pkg::C_CHIP;
      end
    end
    if (o == pfc_pkg::OP_READ) begin
      c = '{write: 1'b0, addr: a, data: 8'h00};
    end
    return c;
  endfunction : seq_cyc

  // Is this read the finished value? Program: bit seven true; erase: one
  function automatic logic poll_ok(input pfc_pkg::pfc_op_e o, input logic [7:0] r,
      input logic [7:0] d);
    if (o == pfc_pkg::OP_PROGRAM) begin
      poll_ok = (r[pfc_pkg::POLL_BIT] == d[pfc_pkg::POLL_BIT]);
    end else begin
      poll_ok = r[pfc_pkg::POLL_BIT];
    end
  endfunction : poll_ok

  pfc_cycle u_cycle (
    .clock(clock),
    .arst_n(arst_n),
    .req_valid(cyc_valid),
    .req_ready(cyc_ready),
    .req(cyc_req),
    .done(cyc_done),
    .rdata(cyc_rdata),
    .pins(pins),
    .dq_in(dq_in)
  );

  //////////////////////////////////////////////////////////////////////////
  // APB slave: zero wait states, errors on unmapped addresses
  assign pready = 1'b1;
  wire apb_wr = psel && penable && pwrite;
  wire start = apb_wr && paddr == pfc_pkg::REG_CTRL && pwdata[pfc_pkg::CTRL_START];

  logic [31:0] next_prdata;

  always_comb begin
    pslverr = 1'b0;
    next_prdata = 32'h0000_0000;
    case (paddr)
      pfc_pkg::REG_CTRL: next_prdata = {29'h0, op};
      pfc_pkg::REG_ADDR: next_prdata = {13'h0, tgt_addr};
      pfc_pkg::REG_DATA: next_prdata = {24'h0, tgt_data};
      pfc_pkg::REG_STAT: next_prdata = {28'h0, id_mode, fail_flag, done_flag, busy};
      pfc_pkg::REG_RDATA: next_prdata = {24'h0, read_data};
      default: pslverr = psel && penable;
    endcase
  end

  // Read word captured in the setup cycle: prdata comes from a flop, still zero wait
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable) begin
      prdata <= next_prdata;
    end
  end

  // Target address and data; frozen while busy so the sequence stays whole
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      tgt_addr <= 19'h00000;
      tgt_data <= 8'h00;
    end else if (apb_wr && !busy) begin
      if (paddr == pfc_pkg::REG_ADDR) tgt_addr <= pwdata[18:0];
      if (paddr == pfc_pkg::REG_DATA) tgt_data <= pwdata[7:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Issue one bus cycle per step; request held until taken
  assign cyc_req = (state == ST_SEQ) ? seq_cyc(op, step, tgt_addr, tgt_data)
                 : pfc_pkg::pfc_cyc_s'{write: 1'b0, addr: tgt_addr, data: 8'h00};
  assign cyc_valid = !issued && (state == ST_SEQ || state == ST_POLL || state == ST_CHECK);

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      issued <= 1'b0;
    end else if (cyc_done) begin
      issued <= 1'b0;
    end else if (cyc_valid && cyc_ready) begin
      issued <= 1'b1;
    end
  end

  // Operation sequencer
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state <= ST_IDLE;
      op <= pfc_pkg::OP_READ;
      busy <= 1'b0;
      done_flag <= 1'b0;
      fail_flag <= 1'b0;
      id_mode <= 1'b0;
      step <= 3'd0;
      recheck <= 2'd0;
      poll_cnt <= 32'h0;
      read_data <= 8'h00;
      prev_rd <= 8'h00;
      have_prev <= 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          // New orders only once the last one has been confirmed finished or its poll budget ran out
          if (start) begin
            op <= pfc_pkg::pfc_op_e'(pwdata[pfc_pkg::CTRL_OP_LSB +: pfc_pkg::CTRL_OP_W]);
            busy <= 1'b1;
            done_flag <= 1'b0;
            fail_flag <= 1'b0;
            step <= 3'd0;
            state <= ST_SEQ;
          end
        end
        ST_SEQ: begin
          if (cyc_done) begin
            if (op == pfc_pkg::OP_READ) begin
              read_data <= cyc_rdata;
              state <= ST_FIN;
            end else if (step == seq_len(op) - 3'd1) begin
              if (op == pfc_pkg::OP_ID_ENTRY) id_mode <= 1'b1;
              if (op == pfc_pkg::OP_ID_EXIT) id_mode <= 1'b0;
              poll_cnt <= 32'h0;
              have_prev <= 1'b0;
              recheck <= 2'd0;
              // ID commands start no internal operation
              state <= (op == pfc_pkg::OP_ID_ENTRY || op == pfc_pkg::OP_ID_EXIT)
                       ? ST_FIN : ST_POLL;
            end else begin
              step <= step + 3'd1;
            end
          end
        end
        ST_POLL: begin
          if (cyc_done) begin
            poll_cnt <= poll_cnt + 32'h1;
            prev_rd <= cyc_rdata;
            have_prev <= 1'b1;
            // Done when bit seven says so and bit six stopped flipping
            if (poll_ok(op, cyc_rdata, tgt_data) && have_prev &&
                prev_rd[pfc_pkg::FLIP_BIT] == cyc_rdata[pfc_pkg::FLIP_BIT]) begin
              recheck <= 2'd0;
              state <= ST_CHECK;
            end else if (poll_cnt >= POLL_MAX) begin
              fail_flag <= 1'b1;
              state <= ST_FIN;
            end
          end
        end
        ST_CHECK: begin
          // Completion may race the read; demand two more clean reads
          if (cyc_done) begin
            read_data <= cyc_rdata;
            if (!poll_ok(op, cyc_rdata, tgt_data)) begin
              state <= ST_POLL;
            end else if (recheck == 2'(pfc_pkg::REREADS - 1)) begin
              state <= ST_FIN;
            end else begin
              recheck <= recheck + 2'd1;
            end
          end
        end
        ST_FIN: begin
          busy <= 1'b0;
          done_flag <= 1'b1;
          state <= ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  a_busy_ignores: assert property (@(posedge clock) disable iff (!arst_n)
    busy && start |=> $stable(op))
    else $error("command taken while busy");
  a_check_rereads: assert property (@(posedge clock) disable iff (!arst_n)
    state == ST_CHECK && $past(state) == ST_POLL |-> recheck == 2'd0)
    else $error("reread count not reset");
  a_fin_from_poll: assert property (@(posedge clock) disable iff (!arst_n)
    $rose(done_flag) && !fail_flag && (op == pfc_pkg::OP_PROGRAM) |->
      read_data[pfc_pkg::POLL_BIT] == tgt_data[pfc_pkg::POLL_BIT])
    else $error("program finished on complemented data");
  a_sector_addr: assert property (@(posedge clock) disable iff (!arst_n)
    state == ST_SEQ && op == pfc_pkg::OP_SECTOR && step == 3'd5 |->
      cyc_req.data == pfc_pkg::C_SECTOR && cyc_req.addr[11:0] == 12'h000)
    else $error("bad sector erase cycle");
  a_unlock_first: assert property (@(posedge clock) disable iff (!arst_n)
    state == ST_SEQ && op != pfc_pkg::OP_READ && step == 3'd0 |->
      cyc_req.addr == pfc_pkg::A_UNLOCK1 && cyc_req.data == pfc_pkg::D_UNLOCK1)
    else $error("sequence without unlock");
  a_chip_last: assert property (@(posedge clock) disable iff (!arst_n)
    state == ST_SEQ && op == pfc_pkg::OP_CHIP && step == 3'd5 |->
      cyc_req.addr == pfc_pkg::A_UNLOCK1 && cyc_req.data == pfc_pkg::C_CHIP)
    else $error("bad chip erase cycle");
  a_prog_fourth: assert property (@(posedge clock) disable iff (!arst_n)
    state == ST_SEQ && op == pfc_pkg::OP_PROGRAM && step == 3'd3 |->
      cyc_req.addr == tgt_addr && cyc_req.data == tgt_data)
    else $error("bad program data cycle");
  a_idle_not_busy: assert property (@(posedge clock) disable iff (!arst_n)
    state == ST_FIN |=> !busy && done_flag)
    else $error("finish did not clear busy");

  c_program: cover property (@(posedge clock) disable iff (!arst_n)
    op == pfc_pkg::OP_PROGRAM && $rose(done_flag));
  c_sector: cover property (@(posedge clock) disable iff (!arst_n)
    op == pfc_pkg::OP_SECTOR && $rose(done_flag));
  c_id_mode: cover property (@(posedge clock) disable iff (!arst_n) $rose(id_mode));
  c_recheck_fail: cover property (@(posedge clock) disable iff (!arst_n)
    state == ST_CHECK ##1 state == ST_POLL);
endmodule : pfc_host

// ---- pfc_flash_model.sv ----
// Behavioural model of the byte-wide parallel flash seen on the host pins
`timescale 1ns/1ps
module pfc_flash_model #(
  parameter logic [7:0] MAKER_CODE = 8'h3c, // Arbitrary value
  parameter logic [7:0] PART_CODE = 8'h4e, // Arbitrary value
  parameter int PROG_NS = 2000,
  parameter int ERASE_NS = 5000
) (
  input pfc_pkg::pfc_pins_s pins,
  input wire logic hang,
  output logic [7:0] dq,
  output logic busy
);
  // Stored inverted so the array powers up erased
  bit [7:0] mem_n [0:524287];
  logic id_mode = 1'b0;
  logic flip = 1'b0;
  logic erasing = 1'b0;
  logic [7:0] prog_val = 8'h00;
  logic [18:0] lat_addr = '0;
  logic [7:0] val;
  logic [7:0] last = 8'h00;
  realtime t_fall = 0;
  int seq = 0;
  int run_ns = 0;
  event start_ev;
  wire wr_act = !pins.ce_n && !pins.we_n && pins.oe_n;
  wire rd_act = !pins.ce_n && !pins.oe_n;
  initial busy = 1'b0;
  //////////////////////////////////////////////////////////////////////////////
  // Command decoder; anything off-sequence restarts the unlock sequence; a lone f0 write also clears id_mode
  task automatic step(input logic [18:0] a, input logic [7:0] d);
    logic c5;
    logic c2;
    c5 = a[14:0] == 15'h5555;
    c2 = a[14:0] == 15'h2aaa;
    if (busy) return;
    case (seq)
      0, 4: begin
        if (seq == 0 && d == 8'hf0) id_mode = 1'b0;
        seq = (c5 && d == 8'haa) ? seq + 1 : 0;
      end
      1, 5: seq = (c2 && d == 8'h55) ? seq + 1 : 0;
      2: begin
        seq = 0;
        if (c5 && d == 8'ha0) seq = 3;
        if (c5 && d == 8'h80) seq = 4;
        if (c5 && d == 8'h90) id_mode = 1'b1;
        if (c5 && d == 8'hf0) id_mode = 1'b0;
      end
      3: begin
        seq = 0;
        prog_val = d;
        mem_n[a] = mem_n[a] | ~d;
        erasing = 1'b0;
        run_ns = PROG_NS;
        busy = 1'b1;
        -> start_ev;
      end
      default: begin
        seq = 0;
        if (d == 8'h30 || (d == 8'h10 && c5)) begin
          for (int i = 0; i < 524288; i++) begin
            if (d == 8'h10 || i[18:12] == a[18:12]) mem_n[i] = 8'h00;
          end
          erasing = 1'b1;
          run_ns = ERASE_NS;
          busy = 1'b1;
          -> start_ev;
        end
      end
    endcase
  endtask : step
  //////////////////////////////////////////////////////////////////////////////
  // Address at the later falling strobe, data at the earlier rising one
  always @(posedge wr_act) begin
    lat_addr = pins.addr;
    t_fall = $realtime;
  end
  // Glitches shorter than 5 ns never start a write cycle
  always @(negedge wr_act) begin
    if ($realtime - t_fall >= 5.0) step(lat_addr, pins.dq_out);
  end
  // Internal operation always runs to the end; hang stretches it on request
  always @(start_ev) begin
    #(run_ns);
    wait (hang == 1'b0);
    busy = 1'b0;
  end
  // Each read while busy flips the status bit
  always @(posedge rd_act) begin
    if (busy) flip = ~flip;
  end
  //////////////////////////////////////////////////////////////////////////////
  // Read data; a released bus shows the inverse of the last value, not a stale one
  always @* begin
    if (busy) val = {erasing ? 1'b0 : ~prog_val[7], flip, ~mem_n[pins.addr][5:0]};
    else if (id_mode && pins.addr == 19'h0) val = MAKER_CODE;
    else if (id_mode && pins.addr == 19'h1) val = PART_CODE;
    else val = ~mem_n[pins.addr];
  end
  always @* begin
    if (rd_act) last = val;
  end
  assign dq = rd_act ? val : ~last;
endmodule : pfc_flash_model

// ---- test_parallel_flash_command_state_machine.sv ----
// Self-checking bench for the parallel flash host controller
`timescale 1ns/1ps
module test_parallel_flash_command_state_machine;
  localparam int TIMEOUT_CYC = 60000;
  localparam logic [7:0] MAKER = 8'h3c; // Arbitrary value
  localparam logic [7:0] PART = 8'h4e; // Arbitrary value
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  pfc_pkg::pfc_pins_s pins;
  logic [7:0] flash_dq;
  logic [7:0] dq_in;
  logic hang = 1'b0;
  logic flash_busy;
  logic err;
  logic [31:0] rd;
  int error_cnt = 0;
  int check_count = 0;
  int cycles = 0;
  always #12.5 clock = ~clock;
  // Host drives the data bus when its enable is low, else the flash does
  assign dq_in = pins.dq_oe_n ? flash_dq : pins.dq_out;
  pfc_host #(.POLL_MAX(64)) u_dut (.clock(clock), .arst_n(arst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pins(pins), .dq_in(dq_in));
  pfc_flash_model #(.MAKER_CODE(MAKER), .PART_CODE(PART)) u_flash (.pins(pins),
    .hang(hang), .dq(flash_dq), .busy(flash_busy));
  //////////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : stop_test
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  // One APB transfer; read data is taken at the edge that sees pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) @(posedge clock);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask : wr
  task automatic rdr(input logic [7:0] a, output logic [31:0] q);
    logic e;
    apb(1'b0, a, 32'h0, q, e);
  endtask : rdr
  task automatic start_op(input logic [2:0] op, input logic [18:0] a, input logic [7:0] d);
    wr(pfc_pkg::REG_ADDR, {13'h0, a});
    wr(pfc_pkg::REG_DATA, {24'h0, d});
    wr(pfc_pkg::REG_CTRL, {23'h0, 1'b1, 5'h0, op});
  endtask : start_op
  // Bounded wait on the busy flag
  task automatic wait_idle();
    logic [31:0] s;
    int n;
    s = 32'h1;
    n = 0;
    while (s[pfc_pkg::STAT_BUSY] !== 1'b0 && n < 5000) begin
      rdr(pfc_pkg::REG_STAT, s);
      n++;
    end
    check({31'h0, s[pfc_pkg::STAT_BUSY]}, 32'h0);
  endtask : wait_idle
  task automatic flash_read(input logic [18:0] a, input logic [7:0] exp);
    logic [31:0] q;
    start_op(pfc_pkg::OP_READ, a, 8'h00);
    wait_idle();
    rdr(pfc_pkg::REG_RDATA, q);
    check({24'h0, q[7:0]}, {24'h0, exp});
  endtask : flash_read
  //////////////////////////////////////////////////////////////////////////////
  // Pin-level watch and hang guard
  always @(posedge clock) begin
    cycles++;
    if (arst_n && !pins.we_n) check({30'h0, pins.oe_n, pins.ce_n}, 32'h2);
    if (arst_n && !pins.oe_n) check({31'h0, pins.dq_oe_n}, 32'h1);
    if (cycles == TIMEOUT_CYC) begin
      error_cnt++;
      stop_test();
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge clock);
    arst_n <= 1'b1;
    rdr(pfc_pkg::REG_STAT, rd);
    check(rd, 32'h0);
    apb(1'b0, 8'h20, 32'h0, rd, err);
    check({31'h0, err}, 32'h1);
    // Identification entry, both codes, then exit back to array reads
    start_op(pfc_pkg::OP_ID_ENTRY, 19'h0, 8'h00);
    wait_idle();
    rdr(pfc_pkg::REG_STAT, rd);
    check({31'h0, rd[pfc_pkg::STAT_ID]}, 32'h1);
    flash_read(19'h0, MAKER);
    flash_read(19'h1, PART);
    start_op(pfc_pkg::OP_ID_EXIT, 19'h0, 8'h00);
    wait_idle();
    rdr(pfc_pkg::REG_STAT, rd);
    check({31'h0, rd[pfc_pkg::STAT_ID]}, 32'h0);
    flash_read(19'h0, 8'hff);
    // Sector erase, then programs with both poll polarities
    start_op(pfc_pkg::OP_SECTOR, 19'h12345, 8'h00);
    wait_idle();
    rdr(pfc_pkg::REG_STAT, rd);
    check({30'h0, rd[pfc_pkg::STAT_FAIL], rd[pfc_pkg::STAT_DONE]}, 32'h1);
    flash_read(19'h12000, 8'hff);
    start_op(pfc_pkg::OP_PROGRAM, 19'h12345, 8'h5a);
    wait_idle();
    flash_read(19'h12345, 8'h5a);
    start_op(pfc_pkg::OP_PROGRAM, 19'h12346, 8'hc3);
    wait_idle();
    flash_read(19'h12346, 8'hc3);
    // Register writes while busy must be dropped
    start_op(pfc_pkg::OP_PROGRAM, 19'h12347, 8'h11);
    wr(pfc_pkg::REG_ADDR, 32'h00777);
    // A new start while busy must be dropped, or the chip erase would wipe the array
    start_op(pfc_pkg::OP_CHIP, 19'h00777, 8'hee);
    wait_idle();
    rdr(pfc_pkg::REG_ADDR, rd);
    check(rd, 32'h12347);
    flash_read(19'h12347, 8'h11);
    flash_read(19'h12345, 8'h5a);
    // Chip erase wipes everything
    start_op(pfc_pkg::OP_CHIP, 19'h0, 8'h00);
    wait_idle();
    flash_read(19'h12345, 8'hff);
    // Flash that never finishes: the host must give up and flag it
    @(posedge clock);
    hang <= 1'b1;
    start_op(pfc_pkg::OP_PROGRAM, 19'h00010, 8'h00);
    wait_idle();
    rdr(pfc_pkg::REG_STAT, rd);
    check({31'h0, rd[pfc_pkg::STAT_FAIL]}, 32'h1);
    hang <= 1'b0;
    for (int i = 0; i < 1000 && flash_busy; i++) @(posedge clock);
    flash_read(19'h00010, 8'h00);
    stop_test();
  end
endmodule : test_parallel_flash_command_state_machine
